// *** design/rsw_decoder.sv ***
// Redundancy switch command decoder: APB command registers, validation,
// switch state, learn/copy/test sequencing.
// Assumes pins from the chassis are asynchronous and are synchronised here.
`timescale 1ns/10ps
module rsw_decoder #(
	parameter logic [7:0] DEV_ID = rsw_pkg::DEV_ID_DEF
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [9:0]            present_pin,
	input  wire logic [7:0]            alarm_pin,
	input  wire logic                  copy_done_pin,
	input  wire logic                  copy_fail_pin,
	output rsw_pkg::rsw_ctrl_type      ctrl,
	output logic [9:0]                 learn_pulse,
	output logic [9:0]                 test_pulse,
	output logic                       copy_req,
	output logic                       copy_demod,
	output logic [3:0]                 copy_src,
	output logic [3:0]                 copy_dst
);
	import rsw_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_COPY_MOD, ST_COPY_DEM} rsw_state_type;

	rsw_state_type state_reg;
	logic [15:0]   opcode_reg;
	logic [31:0]   arg0_reg;
	logic [15:0]   arg1_reg;
	logic [31:0]   resp0_reg;
	logic [15:0]   resp1_reg;
	logic [7:0]    err_reg;
	logic          cfg_ch9_backup_reg;
	logic [9:0]    cfg_assign_reg;
	logic [9:0]    learned_reg;
	logic [7:0]    alarm_reg;
	rsw_stamp_type stamp_reg;
	logic [9:0]    pres_s1_reg;
	logic [9:0]    pres_reg;
	logic [7:0]    alm_s1_reg;
	logic [7:0]    alm_reg;
	logic [2:0]    cdone_reg;
	logic [2:0]    cfail_reg;
	logic          wr_en;
	logic          rd_en;
	logic          go;
	logic [7:0]    b0;
	logic [7:0]    b1;
	logic [7:0]    b2;
	logic [7:0]    b3;
	logic [7:0]    b4;
	logic [7:0]    b5;
	logic [7:0]    chan_max;
	logic [9:0]    backup_set;
	logic          backup_ok;
	logic          cp_done;
	logic          cp_fail;

	// Channel number within 0..max
	function automatic logic in_rng(input logic [7:0] v, input logic [7:0] mx);
		in_rng = (v <= mx);
	endfunction

	// Force byte legal: 255 or both nibbles within 0..max
	function automatic logic force_ok(input logic [7:0] v, input logic [7:0] mx);
		force_ok = (v == NO_FORCE) ||
			(in_rng({4'h0, v[3:0]}, mx) && in_rng({4'h0, v[7:4]}, mx));
	endfunction

	// Nonzero nibble equal in both force bytes
	function automatic logic force_clash(input logic [7:0] a, input logic [7:0] b);
		force_clash = (a != NO_FORCE) && (b != NO_FORCE) &&
			(((a[3:0] == b[3:0]) && (a[3:0] != 4'h0)) ||
			((a[7:4] == b[7:4]) && (a[7:4] != 4'h0)));
	endfunction

	// Argument bytes in arrival order
	assign b0 = arg0_reg[7:0];
	assign b1 = arg0_reg[15:8];
	assign b2 = arg0_reg[23:16];
	assign b3 = arg0_reg[31:24];
	assign b4 = arg1_reg[7:0];
	assign b5 = arg1_reg[15:8];
	assign chan_max = cfg_ch9_backup_reg ? 8'h08 : MODEM_MAX;
	assign backup_set = {cfg_ch9_backup_reg, 9'h001};
	assign backup_ok = pres_reg[0] | (cfg_ch9_backup_reg & pres_reg[9]);
	assign cp_done = cdone_reg[1] & ~cdone_reg[2];
	assign cp_fail = cfail_reg[1] & ~cfail_reg[2];

	////////////////////////////////////////////////////////////////////////////
	// APB access: one wait cycle, then pready with registered data
	assign rd_en = psel & penable & ~pready & ~pwrite;
	assign wr_en = psel & penable & pready & pwrite;
	assign go = wr_en & (paddr == OFF_CMD) & (state_reg == ST_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= 1'b0;
			if (rd_en) begin
				case (paddr)
					OFF_CMD:    prdata <= {16'h0000, opcode_reg};
					OFF_ARG0:   prdata <= arg0_reg;
					OFF_ARG1:   prdata <= {16'h0000, arg1_reg};
					OFF_STATUS: prdata <= {16'h0000, err_reg, 6'h00,
						err_reg != ERR_NONE, state_reg != ST_IDLE};
					OFF_RESP0:  prdata <= resp0_reg;
					OFF_RESP1:  prdata <= {16'h0000, resp1_reg};
					OFF_CONFIG: prdata <= {21'h000000, cfg_assign_reg, cfg_ch9_backup_reg};
					OFF_ALARM:  prdata <= {24'h000000, alarm_reg};
					OFF_LEARN:  prdata <= {22'h000000, learned_reg};
					default: begin
						prdata  <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end else if (psel & penable & ~pready & pwrite) begin
				pslverr <= ~(paddr inside {OFF_CMD, OFF_ARG0, OFF_ARG1, OFF_CONFIG});
			end
		end
	end

	// Software-written argument, command and configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opcode_reg         <= 16'h0000;
			arg0_reg           <= 32'h0000_0000;
			arg1_reg           <= 16'h0000;
			cfg_ch9_backup_reg <= 1'b1;
			cfg_assign_reg     <= 10'h000;
		end else if (wr_en) begin
			case (paddr)
				OFF_CMD:    if (go) opcode_reg <= pwdata[15:0];
				OFF_ARG0:   arg0_reg <= pwdata;
				OFF_ARG1:   arg1_reg <= pwdata[15:0];
				OFF_CONFIG: begin
					cfg_ch9_backup_reg <= pwdata[0];
					cfg_assign_reg     <= pwdata[10:1];
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers, plus edge history on the copy answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pres_s1_reg <= 10'h000;
			pres_reg    <= 10'h000;
			alm_s1_reg  <= 8'h00;
			alm_reg     <= 8'h00;
			cdone_reg   <= 3'h0;
			cfail_reg   <= 3'h0;
		end else begin
			pres_s1_reg <= present_pin;
			pres_reg    <= pres_s1_reg;
			alm_s1_reg  <= alarm_pin;
			alm_reg     <= alm_s1_reg;
			cdone_reg   <= {cdone_reg[1:0], copy_done_pin};
			cfail_reg   <= {cfail_reg[1:0], copy_fail_pin};
		end
	end

	// Latched alarms; a new alarm wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_reg <= 8'h00;
		end else if (state_reg == ST_EXEC && opcode_reg == OP_CLR_ALARM) begin
			alarm_reg <= alm_reg;
		end else begin
			alarm_reg <= alarm_reg | alm_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command sequencer, switch state and responses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= ST_IDLE;
			err_reg     <= ERR_NONE;
			resp0_reg   <= 32'h0000_0000;
			resp1_reg   <= 16'h0000;
			ctrl        <= '{mode1: 2'h0, mode2: 2'h0, force1: 8'hff, force2: 8'hff,
				ref_slot: 8'h00, ref_fallback: 3'h0, ref_freq: 2'h0, ctrl_src: 2'h2};
			stamp_reg   <= '0;
			learned_reg <= 10'h000;
			learn_pulse <= 10'h000;
			test_pulse  <= 10'h000;
			copy_req    <= 1'b0;
			copy_demod  <= 1'b0;
			copy_src    <= 4'h0;
			copy_dst    <= 4'h0;
		end else begin
			learn_pulse <= 10'h000;
			test_pulse  <= 10'h000;
			case (state_reg)
				ST_IDLE: if (go) begin
					state_reg <= ST_EXEC;
					err_reg   <= ERR_NONE;
				end
				ST_EXEC: begin
					state_reg <= ST_IDLE;
					case (opcode_reg)
						// Byte b0 is the backup-channel count; modes follow in b1, b2
						OP_SET_MODE: begin
							if (!in_rng(b1, MODE_MAX) ||
								(cfg_ch9_backup_reg && !in_rng(b2, MODE_MAX)))
								err_reg <= ERR_RANGE;
							else begin
								ctrl.mode1 <= b1[1:0];
								if (cfg_ch9_backup_reg) ctrl.mode2 <= b2[1:0];
							end
						end
						OP_CLR_ALARM: ;
						// Byte b0 is the backup-channel count; targets follow in b1, b2
						OP_FORCE: begin
							if (!force_ok(b1, chan_max) ||
								(cfg_ch9_backup_reg && !force_ok(b2, 8'h08)))
								err_reg <= ERR_RANGE;
							else if (cfg_ch9_backup_reg && force_clash(b1, b2))
								err_reg <= ERR_SAME;
							else if ((b1 != NO_FORCE && ctrl.mode1 != MODE_MANUAL[1:0]) ||
								(cfg_ch9_backup_reg && b2 != NO_FORCE &&
								ctrl.mode2 != MODE_MANUAL[1:0]))
								err_reg <= ERR_MODE;
							else begin
								if (b1 != NO_FORCE) ctrl.force1 <= b1;
								if (cfg_ch9_backup_reg && b2 != NO_FORCE) ctrl.force2 <= b2;
							end
						end
						OP_REF_CFG: begin
							if (!in_rng(b1, FALL_MAX) || !in_rng(b2, FREQ_MAX))
								err_reg <= ERR_RANGE;
							else begin
								ctrl.ref_slot     <= b0;
								ctrl.ref_fallback <= b1[2:0];
								ctrl.ref_freq     <= b2[1:0];
							end
						end
						OP_LEARN: begin
							if (!in_rng(b0, MODEM_MAX))
								err_reg <= ERR_RANGE;
							else if (!pres_reg[b0[3:0]])
								err_reg <= ERR_ABSENT;
							else if (!backup_set[b0[3:0]] && !cfg_assign_reg[b0[3:0]])
								err_reg <= ERR_MODE;
							else begin
								learn_pulse[b0[3:0]] <= 1'b1;
								learned_reg[b0[3:0]] <= 1'b1;
							end
						end
						OP_LEARN_ALL: begin
							learn_pulse <= pres_reg & (backup_set | cfg_assign_reg);
							learned_reg <= learned_reg |
								(pres_reg & (backup_set | cfg_assign_reg));
						end
						OP_COPY: begin
							if (!in_rng(b0, MODEM_MAX) || !in_rng(b1, DST_ALL))
								err_reg <= ERR_RANGE;
							else if (b0 == b1)
								err_reg <= ERR_SAME;
							else if (!pres_reg[b0[3:0]] ||
								(b1 != DST_ALL && !pres_reg[b1[3:0]]))
								err_reg <= ERR_ABSENT;
							else if (!learned_reg[b0[3:0]])
								err_reg <= ERR_NOLEARN;
							else begin
								state_reg  <= ST_COPY_MOD;
								copy_req   <= 1'b1;
								copy_demod <= 1'b0;
								copy_src   <= b0[3:0];
								copy_dst   <= b1[3:0];
							end
						end
						OP_TEST: begin
							if (b0 == 8'h00 || !in_rng(b0, chan_max))
								err_reg <= ERR_RANGE;
							else if (!cfg_assign_reg[b0[3:0]] || backup_set[b0[3:0]])
								err_reg <= ERR_MODE;
							else if (!learned_reg[b0[3:0]])
								err_reg <= ERR_NOLEARN;
							else if (!backup_ok)
								err_reg <= ERR_ABSENT;
							else
								test_pulse[b0[3:0]] <= 1'b1;
						end
						OP_TEST_ALL: begin
							if (backup_ok)
								test_pulse <= cfg_assign_reg & learned_reg & ~backup_set;
							else
								err_reg <= ERR_ABSENT;
						end
						OP_QRY_ID:  resp0_reg <= {24'h000000, DEV_ID};
						OP_QRY_SRC: resp0_reg <= {30'h00000000, ctrl.ctrl_src};
						OP_QRY_TIME: resp0_reg <= {8'h00, stamp_reg.second,
							stamp_reg.minute, stamp_reg.hour};
						OP_QRY_DATE: resp0_reg <= {8'h00, stamp_reg.day,
							stamp_reg.month, stamp_reg.year};
						OP_QRY_STAMP: begin
							resp0_reg <= {stamp_reg.hour, stamp_reg.day,
								stamp_reg.month, stamp_reg.year};
							resp1_reg <= {stamp_reg.second, stamp_reg.minute};
						end
						OP_SET_SRC: begin
							if (!in_rng(b0, SRC_MAX)) err_reg <= ERR_RANGE;
							else ctrl.ctrl_src <= b0[1:0];
						end
						OP_SET_TIME: begin
							if (!in_rng(b0, HOUR_MAX) || !in_rng(b1, MIN_MAX) ||
								!in_rng(b2, MIN_MAX))
								err_reg <= ERR_RANGE;
							else begin
								stamp_reg.hour   <= b0;
								stamp_reg.minute <= b1;
								stamp_reg.second <= b2;
							end
						end
						OP_SET_DATE: begin
							if (!in_rng(b0, YEAR_MAX) || !in_rng(b1, MONTH_MAX) ||
								!in_rng(b2, DAY_MAX))
								err_reg <= ERR_RANGE;
							else begin
								stamp_reg.year  <= b0;
								stamp_reg.month <= b1;
								stamp_reg.day   <= b2;
							end
						end
						OP_SET_STAMP: begin
							if (!in_rng(b0, YEAR_MAX) || !in_rng(b1, MONTH_MAX) ||
								!in_rng(b2, DAY_MAX) || !in_rng(b3, HOUR_MAX) ||
								!in_rng(b4, MIN_MAX) || !in_rng(b5, MIN_MAX))
								err_reg <= ERR_RANGE;
							else
								stamp_reg <= {b0, b1, b2, b3, b4, b5};
						end
						default: err_reg <= ERR_OPCODE;
					endcase
				end
				// Modulator step; demodulator only after it succeeds
				ST_COPY_MOD: begin
					if (cp_fail) begin
						state_reg <= ST_IDLE;
						copy_req  <= 1'b0;
						err_reg   <= ERR_MOD;
					end else if (cp_done) begin
						state_reg  <= ST_COPY_DEM;
						copy_demod <= 1'b1;
					end
				end
				ST_COPY_DEM: begin
					if (cp_fail | cp_done) begin
						state_reg  <= ST_IDLE;
						copy_req   <= 1'b0;
						copy_demod <= 1'b0;
						if (cp_fail) err_reg <= ERR_DEMOD;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// *** design/rsw_pkg.sv ***
// Constants and carrier types for the redundancy switch command decoder.
// Assumes an APB master with 32-bit data and byte addresses.
package rsw_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_ARG0   = 8'h04;
	localparam logic [7:0] OFF_ARG1   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_RESP0  = 8'h10;
	localparam logic [7:0] OFF_RESP1  = 8'h14;
	localparam logic [7:0] OFF_CONFIG = 8'h18;
	localparam logic [7:0] OFF_ALARM  = 8'h1c;
	localparam logic [7:0] OFF_LEARN  = 8'h20;
	// Opcodes
	localparam logic [15:0] OP_SET_MODE   = 16'h2204;
	localparam logic [15:0] OP_CLR_ALARM  = 16'h2205;
	localparam logic [15:0] OP_FORCE      = 16'h2206;
	localparam logic [15:0] OP_REF_CFG    = 16'h2210;
	localparam logic [15:0] OP_LEARN      = 16'h2216;
	localparam logic [15:0] OP_LEARN_ALL  = 16'h2217;
	localparam logic [15:0] OP_COPY       = 16'h2218;
	localparam logic [15:0] OP_TEST       = 16'h2219;
	localparam logic [15:0] OP_TEST_ALL   = 16'h221a;
	localparam logic [15:0] OP_QRY_ID     = 16'h2403;
	localparam logic [15:0] OP_QRY_SRC    = 16'h2404;
	localparam logic [15:0] OP_QRY_TIME   = 16'h240e;
	localparam logic [15:0] OP_QRY_DATE   = 16'h240f;
	localparam logic [15:0] OP_QRY_STAMP  = 16'h2410;
	localparam logic [15:0] OP_SET_SRC    = 16'h2600;
	localparam logic [15:0] OP_SET_TIME   = 16'h2c04;
	localparam logic [15:0] OP_SET_DATE   = 16'h2c05;
	localparam logic [15:0] OP_SET_STAMP  = 16'h2c06;
	// Error codes in STATUS[15:8]
	localparam logic [7:0] ERR_NONE    = 8'h00;
	localparam logic [7:0] ERR_OPCODE  = 8'h01;
	localparam logic [7:0] ERR_RANGE   = 8'h02;
	localparam logic [7:0] ERR_SAME    = 8'h03;
	localparam logic [7:0] ERR_MODE    = 8'h04;
	localparam logic [7:0] ERR_ABSENT  = 8'h05;
	localparam logic [7:0] ERR_NOLEARN = 8'h06;
	localparam logic [7:0] ERR_MOD     = 8'h07;
	localparam logic [7:0] ERR_DEMOD   = 8'h08;
	// Field limits and codes
	localparam logic [7:0] MODE_MANUAL = 8'h00;
	localparam logic [7:0] MODE_MAX    = 8'h02;
	localparam logic [7:0] NO_FORCE    = 8'hff;
	localparam logic [7:0] FALL_MAX    = 8'h06;
	localparam logic [7:0] FREQ_MAX    = 8'h03;
	localparam logic [7:0] SRC_MAX     = 8'h02;
	localparam logic [7:0] MODEM_MAX   = 8'h09;
	localparam logic [7:0] DST_ALL     = 8'h0a;
	localparam logic [7:0] HOUR_MAX    = 8'h17;
	localparam logic [7:0] MIN_MAX     = 8'h3b;
	localparam logic [7:0] YEAR_MAX    = 8'h63;
	localparam logic [7:0] MONTH_MAX   = 8'h0b;
	localparam logic [7:0] DAY_MAX     = 8'h1e;
	localparam logic [7:0] SRC_RESET   = 8'h02;
	// Arbitrary identification value
	localparam logic [7:0] DEV_ID_DEF  = 8'h5a;

	typedef struct packed {
		logic [1:0] mode1;
		logic [1:0] mode2;
		logic [7:0] force1;
		logic [7:0] force2;
		logic [7:0] ref_slot;
		logic [2:0] ref_fallback;
		logic [1:0] ref_freq;
		logic [1:0] ctrl_src;
	} rsw_ctrl_type;

	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} rsw_stamp_type;
endpackage

// *** dv/rsw_chassis_model.sv ***
// Chassis model answering the decoder's copy steps on the done and fail pins.
// Assumes copy_req and copy_demod from the decoder; pins idle low.
`timescale 1ns/10ps
module rsw_chassis_model (
	input wire logic	pclk,
	input wire logic	copy_req,
	input wire logic	copy_demod,
	input wire logic [1:0]	fail_sel,
	input wire logic	slow,
	output logic		copy_done_pin,
	output logic		copy_fail_pin
);
	logic step;
	initial begin
		copy_done_pin = 1'b0;
		copy_fail_pin = 1'b0;
	end
	// Serve one step, then wait until the decoder moves on
	always begin
		@(posedge pclk iff copy_req === 1'b1);
		step = copy_demod;
		repeat (slow ? 20 : 2) @(posedge pclk);
		if (fail_sel[step])
			copy_fail_pin <= 1'b1;
		else
			copy_done_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		copy_done_pin <= 1'b0;
		copy_fail_pin <= 1'b0;
		@(posedge pclk iff (copy_req !== 1'b1 || copy_demod !== step));
	end
endmodule

// *** dv/rsw_decoder_assertions.sv ***
// Port checker for the command decoder.
// Assumes it is bound onto rsw_decoder and sees only its ports.
`timescale 1ns/10ps
module rsw_decoder_assertions (
	input wire logic		pclk,
	input wire logic		presetn,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [7:0]		paddr,
	input wire logic [31:0]		prdata,
	input wire logic		pready,
	input wire logic		pslverr,
	input wire logic		copy_done_pin,
	input wire logic		copy_fail_pin,
	input wire rsw_pkg::rsw_ctrl_type	ctrl,
	input wire logic [9:0]		learn_pulse,
	input wire logic [9:0]		test_pulse,
	input wire logic		copy_req,
	input wire logic		copy_demod,
	input wire logic [3:0]		copy_src,
	input wire logic [3:0]		copy_dst
);
	import rsw_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [1:0] since_reg;
	////////////////////////////////////////////////////////////////////////
	// Cycles since the last completed command write, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since_reg <= 2'h3;
		else if (psel && penable && pready && pwrite && paddr == OFF_CMD)
			since_reg <= 2'h0;
		else if (since_reg != 2'h3)
			since_reg <= since_reg + 2'h1;
	end
	////////////////////////////////////////////////////////////////////////
	// Copy step outcomes seen at the chassis pins
	sequence s_mod_ok;
		copy_req && !copy_demod && !copy_done_pin ##1 copy_done_pin && !copy_fail_pin;
	endsequence
	sequence s_mod_bad;
		copy_req && !copy_demod && !copy_fail_pin ##1 copy_fail_pin;
	endsequence
	a_ready_second: assert property ((psel && !penable) ##1 (psel && penable && !pready) |=> pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read data not zero");
	a_ctrl_by_cmd: assert property ($changed(ctrl) |-> since_reg <= 2'h2)
		else $error("control changed without a command");
	a_copy_mod_first: assert property ($rose(copy_req) |-> !copy_demod && copy_src <= 4'h9)
		else $error("copy did not start with modulator step");
	a_copy_args_hold: assert property (copy_req && $past(copy_req) |-> $stable({copy_src, copy_dst}))
		else $error("copy arguments moved during copy");
	a_demod_after_mod: assert property (s_mod_ok |-> ##[1:5] copy_demod)
		else $error("demodulator step did not follow");
	a_fail_stops: assert property (s_mod_bad |-> (!copy_demod) throughout (1'b1 ##[1:6] !copy_req))
		else $error("copy went on after modulator failure");
	a_learn_single: assert property (|learn_pulse |=> (learn_pulse & $past(learn_pulse)) == 10'h0)
		else $error("learn pulse longer than one cycle");
	a_test_single: assert property (|test_pulse |=> (test_pulse & $past(test_pulse)) == 10'h0)
		else $error("test pulse longer than one cycle");
endmodule
bind rsw_decoder rsw_decoder_assertions u_rsw_decoder_assertions (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .copy_done_pin(copy_done_pin),
	.copy_fail_pin(copy_fail_pin), .ctrl(ctrl), .learn_pulse(learn_pulse),
	.test_pulse(test_pulse), .copy_req(copy_req), .copy_demod(copy_demod),
	.copy_src(copy_src), .copy_dst(copy_dst));

// *** dv/rsw_decoder_bench.sv ***
// Testbench for the command decoder: APB tasks and command sequences.
// Assumes the chassis model on the copy pins and the bound checker.
`timescale 1ns/10ps
module rsw_decoder_bench;
	import rsw_pkg::*;
	logic			pclk = 1'b0;
	logic			presetn, psel, penable, pwrite, pready, pslverr, e, slow;
	logic			copy_req, copy_demod, copy_done_pin, copy_fail_pin;
	logic [7:0]		paddr, alarm_pin, cp_seen;
	logic [31:0]		pwdata, prdata, rv;
	logic [9:0]		present_pin, learn_pulse, test_pulse, tp_seen, lp_seen;
	logic [3:0]		copy_src, copy_dst;
	logic [1:0]		fail_sel;
	rsw_ctrl_type		ctrl;
	int			err_count = 0;
	int			num_checks = 0;
	rsw_decoder u_rsw_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .present_pin(present_pin), .alarm_pin(alarm_pin),
		.copy_done_pin(copy_done_pin), .copy_fail_pin(copy_fail_pin), .ctrl(ctrl),
		.learn_pulse(learn_pulse), .test_pulse(test_pulse), .copy_req(copy_req),
		.copy_demod(copy_demod), .copy_src(copy_src), .copy_dst(copy_dst));
	rsw_chassis_model u_rsw_chassis_model (.pclk(pclk), .copy_req(copy_req),
		.copy_demod(copy_demod), .fail_sel(fail_sel), .slow(slow),
		.copy_done_pin(copy_done_pin), .copy_fail_pin(copy_fail_pin));
	always #5 pclk = ~pclk;
	// Sticky record of test pulses and copy arguments
	always @(posedge pclk) begin
		tp_seen <= tp_seen | test_pulse;
		lp_seen <= lp_seen | learn_pulse;
		if (copy_req === 1'b1)
			cp_seen <= {copy_src, copy_dst};
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// One APB transfer, held until pready; data lands in rv and e
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rv = prdata;
		e = pslverr;
		if (pready !== 1'b1)
			chk("pready", 32'h1, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, ex, rv);
	endtask
	// Load arguments, issue opcode, poll until idle, compare the error code
	task automatic cmd(input logic [15:0] op, input logic [31:0] a0, input logic [15:0] a1,
			input logic [7:0] ex);
		int n;
		n = 0;
		apb(1'b1, OFF_ARG0, a0);
		apb(1'b1, OFF_ARG1, {16'h0, a1});
		apb(1'b1, OFF_CMD, {16'h0, op});
		do begin
			apb(1'b0, OFF_STATUS, 32'h0);
			n++;
		end while (rv[0] !== 1'b0 && n < 100);
		chk("status code", {24'h0, ex}, {24'h0, rv[15:8]});
		chk("status error", {31'h0, ex != 8'h00}, {31'h0, rv[1]});
	endtask
	task automatic done(input string nm);
		$display("Test %s ended, %0d mismatches", nm, err_count);
	endtask
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		present_pin = 10'h3ff;
		alarm_pin = 8'h00;
		fail_sel = 2'b00;
		slow = 1'b0;
		tp_seen = 10'h0;
		lp_seen = 10'h0;
		cp_seen = 8'h00;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("reset force", 32'hffff, {ctrl.force1, ctrl.force2});
		chk("reset src", 32'h2, ctrl.ctrl_src);
		rd(OFF_CONFIG, 32'h1, "config");
		rd(OFF_STATUS, 32'h0, "status");
		done("reset");
		for (int m = 0; m < 3; m++) begin
			cmd(OP_SET_MODE, {8'h0, 8'(2 - m), 8'(m), 8'h02}, 16'h0, ERR_NONE);
			chk("mode", {m[1:0], 2'(2 - m)}, {ctrl.mode1, ctrl.mode2});
		end
		cmd(OP_SET_MODE, 32'h00010302, 16'h0, ERR_RANGE);
		chk("mode kept", 32'h8, {ctrl.mode1, ctrl.mode2});
		apb(1'b1, OFF_CONFIG, 32'h0);
		cmd(OP_SET_MODE, 32'h00030002, 16'h0, ERR_NONE);
		chk("mode ch9 prime", 32'h0, {ctrl.mode1, ctrl.mode2});
		apb(1'b1, OFF_CONFIG, 32'h1);
		done("mode");
		cmd(OP_FORCE, 32'h00432102, 16'h0, ERR_NONE);
		chk("force", 32'h2143, {ctrl.force1, ctrl.force2});
		cmd(OP_FORCE, 32'h00121102, 16'h0, ERR_SAME);
		cmd(OP_FORCE, 32'h0005ff02, 16'h0, ERR_NONE);
		chk("force keep", 32'h2105, {ctrl.force1, ctrl.force2});
		cmd(OP_FORCE, 32'h00ff0902, 16'h0, ERR_RANGE);
		cmd(OP_FORCE, 32'h0009ff02, 16'h0, ERR_RANGE);
		cmd(OP_FORCE, 32'h00ff0002, 16'h0, ERR_NONE);
		cmd(OP_SET_MODE, 32'h00000102, 16'h0, ERR_NONE);
		cmd(OP_FORCE, 32'h00ff0302, 16'h0, ERR_MODE);
		chk("force unback", 32'h0005, {ctrl.force1, ctrl.force2});
		done("force");
		for (int f = 0; f < 4; f++) begin
			cmd(OP_REF_CFG, {8'h0, 8'(f), 8'h06, 8'h05}, 16'h0, ERR_NONE);
			chk("ref", {8'h05, 3'h6, 2'(f)}, {ctrl.ref_slot, ctrl.ref_fallback, ctrl.ref_freq});
		end
		cmd(OP_REF_CFG, 32'h00000705, 16'h0, ERR_RANGE);
		cmd(OP_REF_CFG, 32'h00040605, 16'h0, ERR_RANGE);
		chk("ref kept", 32'h3, ctrl.ref_freq);
		for (int s = 0; s < 3; s++) begin
			cmd(OP_SET_SRC, 32'(s), 16'h0, ERR_NONE);
			cmd(OP_QRY_SRC, 32'h0, 16'h0, ERR_NONE);
			apb(1'b0, OFF_RESP0, 32'h0);
			chk("src", 32'(s), {24'h0, rv[7:0]});
		end
		cmd(OP_SET_SRC, 32'h3, 16'h0, ERR_RANGE);
		cmd(OP_QRY_ID, 32'h0, 16'h0, ERR_NONE);
		apb(1'b0, OFF_RESP0, 32'h0);
		chk("id", {24'h0, DEV_ID_DEF}, {24'h0, rv[7:0]});
		cmd(16'h2300, 32'h0, 16'h0, ERR_OPCODE);
		done("ref src id");
		cmd(OP_SET_TIME, 32'h003b3b17, 16'h0, ERR_NONE);
		cmd(OP_SET_TIME, 32'h00000018, 16'h0, ERR_RANGE);
		cmd(OP_QRY_TIME, 32'h0, 16'h0, ERR_NONE);
		rd(OFF_RESP0, 32'h003b3b17, "time");
		cmd(OP_SET_DATE, 32'h001e0b63, 16'h0, ERR_NONE);
		cmd(OP_SET_DATE, 32'h00000c00, 16'h0, ERR_RANGE);
		cmd(OP_QRY_DATE, 32'h0, 16'h0, ERR_NONE);
		rd(OFF_RESP0, 32'h001e0b63, "date");
		cmd(OP_SET_STAMP, 32'h04030210, 16'h0605, ERR_NONE);
		cmd(OP_QRY_STAMP, 32'h0, 16'h0, ERR_NONE);
		rd(OFF_RESP0, 32'h04030210, "stamp low");
		rd(OFF_RESP1, 32'h0605, "stamp high");
		done("time");
		alarm_pin <= 8'h81;
		repeat (4) @(posedge pclk);
		alarm_pin <= 8'h00;
		repeat (4) @(posedge pclk);
		rd(OFF_ALARM, 32'h81, "alarm latched");
		cmd(OP_CLR_ALARM, 32'h0, 16'h0, ERR_NONE);
		rd(OFF_ALARM, 32'h0, "alarm cleared");
		present_pin <= 10'h3f7;
		apb(1'b1, OFF_CONFIG, 32'h15);
		cmd(OP_LEARN, 32'h1, 16'h0, ERR_NONE);
		cmd(OP_LEARN, 32'h2, 16'h0, ERR_MODE);
		cmd(OP_LEARN, 32'h3, 16'h0, ERR_ABSENT);
		cmd(OP_LEARN, 32'ha, 16'h0, ERR_RANGE);
		rd(OFF_LEARN, 32'h2, "learned");
		cmd(OP_TEST, 32'h1, 16'h0, ERR_NONE);
		cmd(OP_TEST, 32'h9, 16'h0, ERR_RANGE);
		apb(1'b1, OFF_CONFIG, 32'h35);
		cmd(OP_TEST, 32'h4, 16'h0, ERR_NOLEARN);
		cmd(OP_LEARN_ALL, 32'h0, 16'h0, ERR_NONE);
		rd(OFF_LEARN, 32'h213, "learn all");
		chk("learn pulses", 32'h213, {22'h0, lp_seen});
		cmd(OP_TEST_ALL, 32'h0, 16'h0, ERR_NONE);
		chk("test pulses", 32'h12, tp_seen);
		done("learn test");
		cmd(OP_COPY, 32'h0201, 16'h0, ERR_NONE);
		chk("copy args", 32'h12, cp_seen);
		slow <= 1'b1;
		cmd(OP_COPY, 32'h0001, 16'h0, ERR_NONE);
		slow <= 1'b0;
		cmd(OP_COPY, 32'h0101, 16'h0, ERR_SAME);
		cmd(OP_COPY, 32'h0301, 16'h0, ERR_ABSENT);
		cmd(OP_COPY, 32'h0502, 16'h0, ERR_NOLEARN);
		cmd(OP_COPY, 32'h0b01, 16'h0, ERR_RANGE);
		fail_sel <= 2'b01;
		cmd(OP_COPY, 32'h0201, 16'h0, ERR_MOD);
		fail_sel <= 2'b10;
		cmd(OP_COPY, 32'h0201, 16'h0, ERR_DEMOD);
		done("copy");
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped read", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, rv);
		apb(1'b1, 8'h44, 32'h1);
		chk("unmapped write", 32'h1, {31'h0, e});
		done("unmapped");
		final_report();
	end
	// Watchdog against a hung handshake
	initial begin
		#300000;
		err_count++;
		$display("[FAIL] watchdog expected end seen timeout");
		final_report();
	end
endmodule
